// ===== led_drv_pkg.sv
package led_drv_pkg;
// Contract
// - Chopper on at startup for dimmer detection
// - Chopper short pulses with dithered period
// - With dimmer, chopper on while mains low
// - Leading edge: hold chopper on after firing
// - Trailing edge: chopper on after trailing edge
// - No dimmer: chop only above threshold
// - Leading edge: chop set percent of period
// - Trailing edge: chop whole dimming period
// - Shutdown faults release supply into undervoltage
// - Retry startup; never finish while fault persists (code: only overtemperature stops detect; short faults trip in ST_RUN)
// - Peak current limit never shuts down
// - Overvoltage latches; clears only below deep undervoltage
// - Aux above threshold raises overvoltage fault
// - Aux below short level raises short fault
// - Temperature sampled each half cycle
// - Sense resistor short from separate comparator
// - Overcurrent ends flyback pulse at once
// - Next pulse normal after overcurrent truncation
// - Flyback pulse starts at a valley
// - Skip valleys when frequency too high
// - Each cycle sample aux into feedback
// - First four half cycles chopper held on
// - Undervoltage resets all logic except the overvoltage latch

    localparam int CLK_MHZ            = 25;
    localparam int DETECT_HALF_CYCLES = 4;
    localparam int CHOP_ON_NS         = 1000;
    localparam int CHOP_BASE_NS       = 10000;
    localparam int MIN_PERIOD_NS      = 5000;
    localparam int KNEE_NS            = 1000;
    localparam int ON_MAX_NS          = 8000;
    localparam int ON_START_NS        = 400;
    localparam int LE_HOLD_US         = 300;
    localparam int LE_CHOP_PCT        = 50;
    localparam int PCT_SCALE          = 100;

    localparam int CHOP_ON_CYC    = (CHOP_ON_NS * CLK_MHZ + 999) / 1000;
    localparam int CHOP_BASE_CYC  = (CHOP_BASE_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_PERIOD_CYC = (MIN_PERIOD_NS * CLK_MHZ + 999) / 1000;
    localparam int KNEE_CYC       = (KNEE_NS * CLK_MHZ + 999) / 1000;
    localparam int ON_MAX_CYC     = (ON_MAX_NS * CLK_MHZ) / 1000;
    localparam int ON_START_CYC   = (ON_START_NS * CLK_MHZ + 999) / 1000;
    localparam int LE_HOLD_CYC    = LE_HOLD_US * CLK_MHZ;

    localparam logic [7:0] LFSR_SEED = 8'h5a;

    typedef enum logic [1:0] {MODE_NONE, MODE_LEADING, MODE_TRAILING} dimmer_mode_t;
    typedef enum logic [1:0] {ST_DETECT, ST_RUN, ST_SHUTDOWN} ctrl_state_t;
    typedef enum logic [1:0] {FS_WAIT, FS_ON, FS_KNEE} fly_state_t;
endpackage : led_drv_pkg

// ===== flyback_if.sv
interface flyback_if;
    logic       enable;
    logic [7:0] on_limit;
    logic       valley;
    logic       over_current;
    logic [9:0] aux_sample;
    logic       gate;
    logic       truncated;
    logic [9:0] feedback;
    logic       fb_valid;
    modport ctrl (output enable, on_limit, valley, over_current, aux_sample,
                  input gate, truncated, feedback, fb_valid);
    modport gen  (input enable, on_limit, valley, over_current, aux_sample,
                  output gate, truncated, feedback, fb_valid);
endinterface : flyback_if

// ===== sync2.sv
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta;

    // Two stages; only the second is read outside
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule : sync2

// ===== flyback_pulse.sv
module flyback_pulse
    import led_drv_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    flyback_if.gen    fb
);
    fly_state_t state;
    fly_state_t next_state;
    logic [7:0] cnt;
    logic [7:0] period_cnt;

    wire logic period_ok = period_cnt >= 8'(MIN_PERIOD_CYC);
    wire logic on_done   = cnt >= fb.on_limit;
    wire logic knee_done = cnt >= 8'(KNEE_CYC - 1);

    // Pulse sequencer: wait for valley, conduct, read knee
    always_comb begin
        next_state = state;
        unique case (state)
            FS_WAIT: if (fb.enable && fb.valley && period_ok) next_state = FS_ON;
            FS_ON:   if (!fb.enable || fb.over_current || on_done) begin
                next_state = FS_KNEE;
            end
            FS_KNEE: if (knee_done) next_state = FS_WAIT;
        endcase
    end

    // Early valleys simply pass by, which is the skip
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state      <= FS_WAIT;
            cnt        <= 8'h00;
            period_cnt <= 8'h00;
            fb.gate    <= 1'b0;
        end else begin
            state      <= next_state;
            cnt        <= (next_state != state) ? 8'h00 : cnt + 8'h01;
            period_cnt <= (next_state == FS_ON && state == FS_WAIT) ? 8'h00 :
                          (&period_cnt ? period_cnt : period_cnt + 8'h01);
            fb.gate    <= (next_state == FS_ON);
        end
    end

    // Truncation flag and knee sample of the aux waveform
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fb.truncated <= 1'b0;
            fb.fb_valid  <= 1'b0;
            fb.feedback  <= 10'h000;
        end else begin
            fb.truncated <= (state == FS_ON) && fb.over_current;
            fb.fb_valid  <= (state == FS_KNEE) && knee_done;
            if (state == FS_KNEE && knee_done) fb.feedback <= fb.aux_sample;
        end
    end

    property p_ocp_cut;
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == FS_ON && fb.over_current) |=> !fb.gate;
    endproperty
    a_ocp_cut: assert property (p_ocp_cut) else $error("gate not cut on overcurrent");

    property p_skip;
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == FS_WAIT && fb.valley && !period_ok) |=> !fb.gate;
    endproperty
    a_skip: assert property (p_skip) else $error("early valley not skipped");

    property p_valley_start;
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(fb.gate) |-> $past(fb.valley);
    endproperty
    a_valley_start: assert property (p_valley_start) else $error("pulse not at valley");
endmodule : flyback_pulse

// ===== led_driver_ctrl.sv
module led_driver_ctrl
    import led_drv_pkg::*;
#(
    parameter int LE_HOLD = LE_HOLD_CYC,
    parameter int CNT_W   = 20
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_por_n,
    input  wire logic         i_mains_low,
    input  wire logic         i_mains_above_chop,
    input  wire logic         i_aux_above_ovp,
    input  wire logic         i_aux_below_short,
    input  wire logic         i_aux_valley,
    input  wire logic         i_isense_above_ocp,
    input  wire logic         i_isense_below_ref,
    input  wire logic         i_temp_at_shutdown,
    input  wire logic [9:0]   i_aux_sample,
    input  wire dimmer_mode_t i_dimmer_mode,
    output logic              o_chopper_gate,
    output logic              o_flyback_gate,
    output logic              o_supply_release,
    output logic              o_output_overvoltage_fault,
    output logic              o_output_short_fault,
    output logic              o_sense_resistor_short_fault,
    output logic              o_overtemp_fault,
    output logic              o_peak_current_limit,
    output logic [9:0]        o_output_voltage_feedback,
    output logic              o_detect_done
);
    localparam int MW = CNT_W + 7;

    // Comparator pins, all asynchronous to the controller clock
    logic [7:0] raw;
    logic [7:0] synced;

    assign raw = {i_mains_low, i_mains_above_chop, i_aux_above_ovp, i_aux_below_short,
                  i_aux_valley, i_isense_above_ocp, i_isense_below_ref,
                  i_temp_at_shutdown};

    sync2 #(
        .W (8)
    ) u_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_async   (raw),
        .o_sync    (synced)
    );

    wire logic mains_low  = synced[7];
    wire logic above_chop = synced[6];
    wire logic aux_ovp    = synced[5];
    wire logic aux_short  = synced[4];
    wire logic valley     = synced[3];
    wire logic isense_ocp = synced[2];
    wire logic below_ref  = synced[1];
    wire logic temp_sd    = synced[0];

    // State
    ctrl_state_t  state;
    ctrl_state_t  next_state;
    dimmer_mode_t mode;
    logic [2:0]   half_cnt;
    logic         mains_low_d;
    logic [CNT_W-1:0] cross_cnt;
    logic [CNT_W-1:0] prev_tcross;
    logic         ovp_latched;
    logic         otp;
    logic         short_flt;
    logic         sense_resistor_short_fault;
    logic         seen_cur;
    logic         gate_d;
    logic [7:0]   on_limit;
    logic [7:0]   lfsr;
    logic [8:0]   per_cnt;
    logic         next_chop;

    flyback_if fb ();

    flyback_pulse u_flyback (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .fb        (fb.gen)
    );

    // Mains edge decode: zero-cross start and line rise
    wire logic hc_start   = mains_low && !mains_low_d;
    wire logic line_rise  = !mains_low && mains_low_d;
    // Only the detect phase may latch the mode; later half cycles leave it alone
    wire logic detect_end = hc_start && (state == ST_DETECT)
                            && (half_cnt == 3'(DETECT_HALF_CYCLES - 1));

    // Faults that force a restart through undervoltage
    wire logic shutdown_fault = otp || short_flt || sense_resistor_short_fault;
    wire logic gates_allowed  = !ovp_latched && !shutdown_fault;
    wire logic soft_done      = on_limit == 8'(ON_MAX_CYC);
    wire logic gate_fall      = gate_d && !fb.gate;

    // Chop pulse with dithered period
    wire logic [8:0] chop_period = 9'(CHOP_BASE_CYC) + {5'h00, lfsr[3:0]};
    wire logic       chop_pulse  = per_cnt < 9'(CHOP_ON_CYC);
    wire logic       lfsr_fb     = lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3];

    // Leading edge chop window as a share of last dimming period
    wire logic [MW-1:0] le_pos  = MW'(cross_cnt) * MW'(PCT_SCALE);
    wire logic [MW-1:0] le_lim  = MW'(prev_tcross) * MW'(LE_CHOP_PCT);
    wire logic          le_win  = le_pos < le_lim;
    wire logic          le_hold = cross_cnt < CNT_W'(LE_HOLD);

    // Flyback side of the carrier
    assign fb.enable       = (state == ST_RUN) && gates_allowed;
    assign fb.on_limit     = on_limit;
    assign fb.valley       = valley;
    assign fb.over_current = isense_ocp;
    assign fb.aux_sample   = i_aux_sample;

    // Top sequence; shutdown waits for the supply to collapse
    always_comb begin
        next_state = state;
        unique case (state)
            ST_DETECT: begin
                if (shutdown_fault) next_state = ST_SHUTDOWN;
                else if (detect_end) next_state = ST_RUN;
            end
            ST_RUN: if (shutdown_fault) next_state = ST_SHUTDOWN;
            ST_SHUTDOWN: next_state = ST_SHUTDOWN;
        endcase
    end

    // Chopper gate per phase and dimmer mode
    always_comb begin
        next_chop = 1'b0;
        if (!gates_allowed) begin
            next_chop = 1'b0;
        end else if (state == ST_DETECT) begin
            next_chop = 1'b1;
        end else if (state == ST_RUN) begin
            unique case (mode)
                MODE_LEADING: begin
                    next_chop = mains_low || le_hold
                                || (le_win && chop_pulse);
                end
                MODE_TRAILING: begin
                    next_chop = mains_low || chop_pulse;
                end
                default: next_chop = above_chop && chop_pulse;
            endcase
        end
    end

    // Sequencer registers; i_reset_n is the undervoltage reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state    <= ST_DETECT;
            mode     <= MODE_NONE;
            half_cnt <= 3'h0;
        end else begin
            state <= next_state;
            if (hc_start && state == ST_DETECT) half_cnt <= half_cnt + 3'h1;
            if (detect_end) mode <= i_dimmer_mode;
        end
    end

    // Half-cycle timing: cycles since line rose, kept per half cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mains_low_d <= 1'b0;
            cross_cnt   <= '0;
            prev_tcross <= '0;
        end else begin
            mains_low_d <= mains_low;
            if (hc_start) prev_tcross <= cross_cnt;
            if (line_rise) cross_cnt <= '0;
            else if (!mains_low && !(&cross_cnt)) cross_cnt <= cross_cnt + CNT_W'(1);
        end
    end

    // Dither: the period moves each chop cycle to spread emissions
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lfsr    <= LFSR_SEED;
            per_cnt <= 9'h000;
        end else if (per_cnt >= chop_period - 9'h001) begin
            per_cnt <= 9'h000;
            lfsr    <= {lfsr[6:0], lfsr_fb};
        end else begin
            per_cnt <= per_cnt + 9'h001;
        end
    end

    // Soft start: on-time limit grows by one cycle per pulse
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            on_limit <= 8'(ON_START_CYC);
        end else if (fb.fb_valid && !soft_done) begin
            on_limit <= on_limit + 8'h01;
        end
    end

    // Overvoltage latch survives the normal undervoltage reset
    always_ff @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            ovp_latched <= 1'b0;
        end else if (aux_ovp) begin
            ovp_latched <= 1'b1;
        end
    end

    // Sticky shutdown faults, cleared only by undervoltage reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            otp       <= 1'b0;
            short_flt <= 1'b0;
            sense_resistor_short_fault      <= 1'b0;
        end else begin
            if (hc_start && temp_sd) otp <= 1'b1;
            // Checked only after soft start, so a low output can ramp
            if (fb.fb_valid && soft_done && aux_short) short_flt <= 1'b1;
            if (gate_fall && !seen_cur) sense_resistor_short_fault <= 1'b1;
        end
    end

    // Sense activity seen during the pulse, separate from overcurrent
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seen_cur <= 1'b0;
            gate_d   <= 1'b0;
        end else begin
            gate_d <= fb.gate;
            if (!fb.gate) seen_cur <= 1'b0;
            else if (!below_ref) seen_cur <= 1'b1;
        end
    end

    // Registered outputs
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_chopper_gate               <= 1'b0;
            o_flyback_gate               <= 1'b0;
            o_supply_release             <= 1'b0;
            o_output_short_fault         <= 1'b0;
            o_sense_resistor_short_fault <= 1'b0;
            o_overtemp_fault             <= 1'b0;
            o_peak_current_limit         <= 1'b0;
            o_output_voltage_feedback    <= 10'h000;
            o_detect_done                <= 1'b0;
        end else begin
            o_chopper_gate               <= next_chop;
            o_flyback_gate               <= fb.gate && gates_allowed;
            o_supply_release             <= (state == ST_SHUTDOWN);
            o_output_short_fault         <= short_flt;
            o_sense_resistor_short_fault <= sense_resistor_short_fault;
            o_overtemp_fault             <= otp;
            o_peak_current_limit         <= fb.truncated;
            o_output_voltage_feedback    <= fb.feedback;
            o_detect_done                <= (state == ST_RUN);
        end
    end

    assign o_output_overvoltage_fault = ovp_latched;

    // Checks on the sequence
    property p_detect_chop;
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_DETECT && gates_allowed) |=> o_chopper_gate;
    endproperty
    a_detect_chop: assert property (p_detect_chop) else $error("chopper low in detect");

    property p_supply;
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_SHUTDOWN) |=> o_supply_release;
    endproperty
    a_supply: assert property (p_supply) else $error("supply not released");

    property p_ocp_run;
        @(posedge i_clk) disable iff (!i_reset_n)
        (fb.truncated && state == ST_RUN && !shutdown_fault) |=> (state == ST_RUN);
    endproperty
    a_ocp_run: assert property (p_ocp_run) else $error("overcurrent left run");

    property p_ovp_hold;
        @(posedge i_clk) disable iff (!i_por_n)
        o_output_overvoltage_fault |=> o_output_overvoltage_fault;
    endproperty
    a_ovp_hold: assert property (p_ovp_hold) else $error("overvoltage latch dropped");

    property p_ovp_set;
        @(posedge i_clk) disable iff (!i_por_n)
        aux_ovp |=> o_output_overvoltage_fault;
    endproperty
    a_ovp_set: assert property (p_ovp_set) else $error("overvoltage not flagged");

    property p_gates_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        !gates_allowed |=> (!o_chopper_gate && !o_flyback_gate);
    endproperty
    a_gates_off: assert property (p_gates_off) else $error("gate on during fault");

    property p_none_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_RUN && mode == MODE_NONE && !above_chop) |=> !o_chopper_gate;
    endproperty
    a_none_off: assert property (p_none_off) else $error("chopper on below threshold");

    property p_low_on;
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == ST_RUN && mode != MODE_NONE && mains_low && gates_allowed)
            |=> o_chopper_gate;
    endproperty
    a_low_on: assert property (p_low_on) else $error("chopper off at low mains");

    property p_temp;
        @(posedge i_clk) disable iff (!i_reset_n)
        (hc_start && temp_sd) |=> ##1 o_overtemp_fault;
    endproperty
    a_temp: assert property (p_temp) else $error("overtemperature missed");

    sequence s_fire;
        state == ST_RUN && mode == MODE_LEADING && line_rise;
    endsequence

    property p_le_hold;
        @(posedge i_clk) disable iff (!i_reset_n)
        s_fire |=> ##1 (o_chopper_gate || !gates_allowed)[*8];
    endproperty
    a_le_hold: assert property (p_le_hold) else $error("no hold after firing");

    property p_short_set;
        @(posedge i_clk) disable iff (!i_reset_n)
        (fb.fb_valid && soft_done && aux_short) |=> ##1 o_output_short_fault;
    endproperty
    a_short_set: assert property (p_short_set) else $error("output short missed");

    sequence s_dead_pulse;
        gate_fall && !seen_cur;
    endsequence

    property p_sense_resistor_short_fault_set;
        @(posedge i_clk) disable iff (!i_reset_n)
        s_dead_pulse |=> ##1 o_sense_resistor_short_fault;
    endproperty
    a_sense_resistor_short_fault_set: assert property (p_sense_resistor_short_fault_set) else $error("sense short missed");

    // A shutdown must never report a finished startup
    property p_no_start;
        @(posedge i_clk) disable iff (!i_reset_n)
        shutdown_fault |=> ##1 !o_detect_done;
    endproperty
    a_no_start: assert property (p_no_start) else $error("startup done during fault");
endmodule : led_driver_ctrl

// ===== power_stage_model.sv
module power_stage_model (
    input  wire logic i_clk,
    input  wire logic i_flyback_gate,
    input  wire logic i_force_ocp,
    input  wire logic i_short_sense,
    output logic      o_mains_low,
    output logic      o_aux_valley,
    output logic      o_isense_above_ocp,
    output logic      o_isense_below_ref
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF_CYC = 600;
    localparam int LOW_CYC  = 60;
    localparam int RING_CYC = 40;
    int phase = 0;
    int ring  = 0;
    // Line runs free; it never waits for the controller
    always @(posedge i_clk) begin
        phase <= (phase == HALF_CYC - 1) ? 0 : phase + 1;
        ring  <= i_flyback_gate ? 0 : ring + 1;
    end
    // Low section opens each half cycle
    assign o_mains_low = phase < LOW_CYC;
    // Drain rings after turn-off, one short valley per ring period
    assign o_aux_valley = !i_flyback_gate && (ring % RING_CYC == RING_CYC - 1);
    // Shorted sense resistor reads zero even with current flowing
    assign o_isense_below_ref = !i_flyback_gate || i_short_sense;
    assign o_isense_above_ocp = i_flyback_gate && i_force_ocp;
endmodule : power_stage_model

// ===== led_driver_chopper_fault_ctrl_bench.sv
module led_driver_chopper_fault_ctrl_bench import led_drv_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic         i_clk       = 1'b0;
    logic         i_reset_n   = 1'b0;
    logic         i_por_n     = 1'b0;
    logic         above_chop  = 1'b0;
    logic         ovp         = 1'b0;
    logic         temp_sd     = 1'b0;
    logic         force_ocp   = 1'b0;
    logic         short_sense = 1'b0;
    logic         aux_short   = 1'b0;
    logic [9:0]   aux         = 10'h000;
    dimmer_mode_t mode        = MODE_NONE;
    logic         mains_low, valley, ocp, below_ref, chop, fly, rel, pcl, done;
    logic         f_ovp, f_short, f_sense_resistor_short_fault, f_otp, fly_prev;
    logic [9:0]   fb;
    logic [9:0]   fb_prev;
    logic [9:0]   fb_q[$];
    int           errors = 0;
    int           comparisons = 0;
    int           seed = 32'hb0b09821;
    int           width = 0;
    int           cnt = 0;
    int           last_rise = 0;
    int           cyc = 0;

    always #20 i_clk = ~i_clk;

    led_driver_ctrl #(.LE_HOLD(20)) u_led_driver_ctrl (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_por_n(i_por_n),
        .i_mains_low(mains_low), .i_mains_above_chop(above_chop),
        .i_aux_above_ovp(ovp), .i_aux_below_short(aux_short), .i_aux_valley(valley),
        .i_isense_above_ocp(ocp), .i_isense_below_ref(below_ref),
        .i_temp_at_shutdown(temp_sd), .i_aux_sample(aux), .i_dimmer_mode(mode),
        .o_chopper_gate(chop), .o_flyback_gate(fly), .o_supply_release(rel),
        .o_output_overvoltage_fault(f_ovp), .o_output_short_fault(f_short),
        .o_sense_resistor_short_fault(f_sense_resistor_short_fault), .o_overtemp_fault(f_otp),
        .o_peak_current_limit(pcl), .o_output_voltage_feedback(fb),
        .o_detect_done(done));

    power_stage_model u_power_stage_model (
        .i_clk(i_clk), .i_flyback_gate(fly), .i_force_ocp(force_ocp),
        .i_short_sense(short_sense), .o_mains_low(mains_low), .o_aux_valley(valley),
        .o_isense_above_ocp(ocp), .o_isense_below_ref(below_ref));

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step

    task automatic check_bit(input logic act, input logic exp, input string what);
        comparisons++;
        if (act !== exp) begin
            errors++;
            $display("Error at %0t: %s is %b, expected %b", $time, what, act, exp);
        end
    endtask : check_bit

    task automatic check_fb(input logic [9:0] act, input logic [9:0] exp);
        comparisons++;
        if (act !== exp) begin
            errors++;
            $display("Error at %0t: feedback %h, expected %h", $time, act, exp);
        end
    endtask : check_fb

    task automatic give_verdict();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // Bounded wait; running out ends the run as a failure
    task automatic wait_level(ref logic s, input logic v, input int lim);
        int i = 0;
        while (s !== v && i < lim) begin
            step(1);
            i++;
        end
        if (s !== v) begin
            errors++;
            $display("Error at %0t: wait ran out", $time);
            give_verdict();
        end
    endtask : wait_level

    task automatic count_high(input int n);
        cnt = 0;
        repeat (n) begin
            step(1);
            cnt += int'(chop === 1'b1);
        end
    endtask : count_high

    task automatic do_reset();
        i_reset_n = 1'b0;
        step(2);
        i_reset_n = 1'b1;
    endtask : do_reset

    // Watcher: pulse spacing and width, feedback notes in order
    always @(posedge i_clk) begin
        #2;
        cyc++;
        if (fly === 1'b1 && fly_prev !== 1'b1) begin
            if (last_rise > 0) check_bit(cyc - last_rise >= MIN_PERIOD_CYC, 1'b1, "spacing");
            last_rise = cyc;
            width = 0;
        end
        if (fly === 1'b1) width++;
        if (fb !== fb_prev && fb_q.size() > 0) check_fb(fb, fb_q.pop_front());
        fb_prev = fb;
        fly_prev = fly;
    end

    initial begin
        step(6);
        check_bit(chop, 1'b0, "gate in reset");
        i_por_n = 1'b1;
        for (int m = 0; m < 3; m++) begin
            mode = dimmer_mode_t'(m);
            above_chop = 1'b0;
            do_reset();
            step(3);
            check_bit(chop, 1'b1, "startup load");
            cnt = 0;
            for (int i = 0; i < 3000 && done !== 1'b1; i++) begin
                step(1);
                if (done !== 1'b1) cnt += int'(chop !== 1'b1);
            end
            check_bit(done, 1'b1, "detect end");
            check_bit(cnt == 0, 1'b1, "detect hold");
            if (done !== 1'b1) give_verdict();
            wait_level(mains_low, 1'b0, 700);
            wait_level(mains_low, 1'b1, 700);
            step(20);
            check_bit(chop, m != 0, "low section");
            step(45);
            count_high(400);
            check_bit(cnt > 0, m != 0, "chopping");
            check_bit(cnt < 400, 1'b1, "pulsed");
            if (m == 1) check_bit(chop, 1'b0, "after window");
            if (m == 0) begin
                above_chop = 1'b1;
                count_high(400);
                check_bit(cnt > 0 && cnt < 400, 1'b1, "above threshold");
            end
            $display("test mode %0d done", m);
        end
        // Random knee samples must show up in order
        repeat (4) begin
            aux = 10'($random(seed));
            if (aux === fb) aux ^= 10'h001;
            fb_q.push_back(aux);
            for (int i = 0; i < 600 && fb_q.size() > 0; i++) step(1);
            check_bit(fb_q.size() == 0, 1'b1, "feedback taken");
            if (fb_q.size() > 0) give_verdict();
        end
        $display("test feedback done");
        force_ocp = 1'b1;
        wait_level(pcl, 1'b1, 600);
        step(3);
        check_bit(width < 10, 1'b1, "cut pulse");
        force_ocp = 1'b0;
        wait_level(fly, 1'b1, 600);
        wait_level(fly, 1'b0, 600);
        step(1);
        check_bit(width >= 10, 1'b1, "next pulse");
        check_bit(rel, 1'b0, "no shutdown");
        $display("test overcurrent done");
        // Short is blanked until soft start ends, so this waits out the ramp
        aux_short = 1'b1;
        wait_level(f_short, 1'b1, 45000);
        step(2);
        check_bit(rel, 1'b1, "short release");
        check_bit(fly | chop, 1'b0, "short gates off");
        aux_short = 1'b0;
        do_reset();
        wait_level(done, 1'b1, 3000);
        $display("test output short done");
        short_sense = 1'b1;
        wait_level(f_sense_resistor_short_fault, 1'b1, 600);
        step(2);
        check_bit(rel, 1'b1, "release");
        check_bit(fly | chop, 1'b0, "gates off");
        short_sense = 1'b0;
        $display("test sense short done");
        do_reset();
        temp_sd = 1'b1;
        wait_level(f_otp, 1'b1, 700);
        step(2);
        check_bit(rel, 1'b1, "temp release");
        do_reset();
        wait_level(f_otp, 1'b1, 700);
        step(2);
        check_bit(done, 1'b0, "no startup");
        temp_sd = 1'b0;
        $display("test temperature done");
        do_reset();
        ovp = 1'b1;
        wait_level(f_ovp, 1'b1, 20);
        ovp = 1'b0;
        do_reset();
        step(3);
        check_bit(f_ovp, 1'b1, "latch kept");
        check_bit(chop, 1'b0, "latched gate");
        i_por_n = 1'b0;
        step(1);
        check_bit(f_ovp, 1'b0, "latch cleared");
        i_por_n = 1'b1;
        $display("test overvoltage done");
        give_verdict();
    end
endmodule : led_driver_chopper_fault_ctrl_bench
